// [src/pll_consts.svh]
// Register offsets, field positions, reset values and lock detector counts
// for the loop divider and lock control block.
// Assumes it is included by its bare name wherever the values are needed.
`ifndef PLL_CONSTS_SVH
`define PLL_CONSTS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define ADDR_CTRL 8'h36
`define ADDR_BW 8'h37
`define ADDR_MUL_HI 8'h38
`define ADDR_MUL_LO 8'h39
`define ADDR_RANGE 8'h3A
`define ADDR_REFDIV 8'h3B

// ****************************************************************
// Field positions
// ****************************************************************
`define CTRL_IE_BIT 7
`define CTRL_FLAG_BIT 6
`define CTRL_ON_BIT 5
`define CTRL_BCS_BIT 4
`define BW_AUTO_BIT 7
`define BW_LOCK_BIT 6
`define BW_ACQ_BIT 5

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_ON 1'h1
`define RST_MUL 12'h040
`define RST_RANGE 8'h40
`define RST_REFDIV 4'h1

// ****************************************************************
// Lock detector: good reference periods needed per step
// ****************************************************************
`define GOOD_ACQ_PERIODS 8'h04
`define GOOD_LOCK_PERIODS 8'h08

`endif

// [src/pll_divider_lock_control.sv]
// Digital control of a frequency-synthesising loop: dividers, phase
// comparator, lock detector, bandwidth mode and control registers.
// Assumes ref_clk far faster than ref_clock_in and vco_clock, which are
// sampled pins; register port strobes come from logic on ref_clk.
//
// Overview of operation
// - Reference pin edges are divided by R to form the divided reference.
// - VCO edges pass a 2^P prescaler, then a modulo-N divider, giving feedback.
// - Phase comparator drives up/down pulses as wide as the phase difference.
// - Lock detector compares feedback and reference rates, once per reference period.
// - acquire_track_select clear means acquisition; set or not acquiring means tracking.
// - With auto bandwidth set, the detector switches filter mode by itself.
// - In auto mode acquire_track_select is read-only, following tolerance.
// - In auto mode the lock indicator is read-only, following tolerance.
// - In auto mode with irq enable, every lock indicator toggle raises interrupt.
// - In manual mode software writes acquire_track_select directly.
// - Manual mode disables the lock indicator and all lock interrupts.
// - Prescaler exponent P takes 0 to 3.
// - Feedback multiplier N is programmable from 1 to 4095.
// - VCO centre set by linear factor L and range exponent E outputs.
// - Without auto bandwidth, lock_irq_enable is forced zero and read-only.
// - Without auto bandwidth, lock_change_flag and lock indicator read zero.
// - While loop_power_on is set, P, E, N, L and R are read-only.
// - R or N programmed as zero acts as one.
`timescale 1ns/1ps
`include "pll_consts.svh"

module pll_divider_lock_control #(
    parameter int N_W = 12,
    parameter int R_W = 4,
    parameter logic [7:0] GOOD_ACQ = `GOOD_ACQ_PERIODS,
    parameter logic [7:0] GOOD_LOCK = `GOOD_LOCK_PERIODS
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Clock pins
    input wire logic ref_clock_in,
    input wire logic vco_clock,
    // Divided clock ticks
    output logic divided_ref_clock,
    output logic prescaled_vco_clock,
    output logic feedback_clock,
    // Loop filter and analog controls
    output pll_pkg::pump_t pump,
    output logic track_mode,
    output logic loop_power_on,
    output logic base_clock_select,
    output logic [7:0] vco_range_linear,
    output logic [1:0] vco_range_exp,
    // Processor interrupt
    output logic lock_irq
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [1:0] pin_in;
    logic [2:0] sync_r [2];
    logic [1:0] stable_r;
    logic [1:0] rise;

    assign pin_in = {vco_clock, ref_clock_in};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_sync
            wire agree = sync_r[gi][1] == sync_r[gi][2];
            assign rise[gi] = agree && sync_r[gi][2] && !stable_r[gi];
            always_ff @(posedge ref_clk) begin
                if (sys_rst) begin
                    sync_r[gi] <= 3'h0;
                    stable_r[gi] <= 1'b0;
                end else begin
                    sync_r[gi] <= {sync_r[gi][1:0], pin_in[gi]};
                    if (agree) begin
                        stable_r[gi] <= sync_r[gi][2];
                    end
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic ie_r, flag_r, on_r, bcs_r, auto_r, acq_r, lock_r;
    logic [1:0] pre_r, exp_r;
    logic [N_W-1:0] mul_r;
    logic [7:0] lin_r;
    logic [R_W-1:0] rds_r;
    logic [7:0] rdata_r;
    logic irq_r;
    logic ie_nxt, flag_nxt, on_nxt, bcs_nxt, acq_nxt, lock_nxt;
    logic [7:0] rd_mux;

    wire wr_ctrl = reg_wr && (reg_addr == `ADDR_CTRL);
    wire wr_bw = reg_wr && (reg_addr == `ADDR_BW);
    wire prog_ok = !on_r;
    wire wr_mhi = reg_wr && (reg_addr == `ADDR_MUL_HI) && prog_ok;
    wire wr_mlo = reg_wr && (reg_addr == `ADDR_MUL_LO) && prog_ok;
    wire wr_rng = reg_wr && (reg_addr == `ADDR_RANGE) && prog_ok;
    wire wr_rds = reg_wr && (reg_addr == `ADDR_REFDIV) && prog_ok;
    wire lock_toggle = auto_r && (lock_nxt != lock_r);

    // Power-on cannot change while the loop drives the base clock
    assign on_nxt = (wr_ctrl && !bcs_r) ? reg_wdata[`CTRL_ON_BIT] : on_r;
    // Base clock selection needs the loop already on and a nonzero L
    assign bcs_nxt = (!on_r || lin_r == 8'h00) ? 1'b0 : (wr_ctrl ? reg_wdata[`CTRL_BCS_BIT] : bcs_r);
    assign ie_nxt = !auto_r ? 1'b0 : (wr_ctrl ? reg_wdata[`CTRL_IE_BIT] : ie_r);
    // Flag is write-one-to-clear; a toggle in the same cycle wins
    assign flag_nxt = !auto_r ? 1'b0 : lock_toggle ? 1'b1 :
        (wr_ctrl && reg_wdata[`CTRL_FLAG_BIT]) ? 1'b0 : flag_r;

    assign rd_mux = (reg_addr == `ADDR_CTRL) ? {ie_r, flag_r, on_r, bcs_r, pre_r, exp_r} :
        (reg_addr == `ADDR_BW) ? {auto_r, lock_r && auto_r, acq_r, 5'h00} :
        (reg_addr == `ADDR_MUL_HI) ? {4'h0, mul_r[11:8]} :
        (reg_addr == `ADDR_MUL_LO) ? mul_r[7:0] :
        (reg_addr == `ADDR_RANGE) ? lin_r :
        (reg_addr == `ADDR_REFDIV) ? {4'h0, rds_r} : 8'h00;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ie_r <= 1'b0;
            flag_r <= 1'b0;
            on_r <= `RST_ON;
            bcs_r <= 1'b0;
            auto_r <= 1'b0;
            acq_r <= 1'b0;
            irq_r <= 1'b0;
            rdata_r <= 8'h00;
        end else begin
            ie_r <= ie_nxt;
            flag_r <= flag_nxt;
            on_r <= on_nxt;
            bcs_r <= bcs_nxt;
            auto_r <= wr_bw ? reg_wdata[`BW_AUTO_BIT] : auto_r;
            acq_r <= acq_nxt;
            irq_r <= flag_nxt && ie_nxt;
            rdata_r <= reg_rd ? rd_mux : 8'h00;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pre_r <= 2'h0;
            exp_r <= 2'h0;
            mul_r <= `RST_MUL;
            lin_r <= `RST_RANGE;
            rds_r <= `RST_REFDIV;
        end else begin
            if (wr_ctrl && prog_ok) begin
                pre_r <= reg_wdata[3:2];
                exp_r <= reg_wdata[1:0];
            end
            if (wr_mhi) begin
                mul_r[11:8] <= reg_wdata[3:0];
            end
            if (wr_mlo) begin
                mul_r[7:0] <= reg_wdata;
            end
            if (wr_rng) begin
                lin_r <= reg_wdata;
            end
            if (wr_rds) begin
                rds_r <= reg_wdata[3:0];
            end
        end
    end

    // ****************************************************************
    // Dividers
    // ****************************************************************
    logic [R_W-1:0] ref_cnt_r;
    logic [2:0] pre_cnt_r;
    logic [N_W-1:0] mod_cnt_r;
    logic rdv_r, pclk_r, fb_r;

    wire [R_W-1:0] r_last = (rds_r == '0) ? '0 : rds_r - 4'h1;
    wire [N_W-1:0] n_last = (mul_r == '0) ? '0 : mul_r - 12'h001;
    wire [2:0] pre_last = 3'((4'h1 << pre_r) - 4'h1);
    wire rdv_tick = on_r && rise[0] && (ref_cnt_r >= r_last);
    wire pclk_tick = on_r && rise[1] && (pre_cnt_r >= pre_last);
    wire fb_tick = pclk_tick && (mod_cnt_r >= n_last);

    always_ff @(posedge ref_clk) begin
        if (sys_rst || !on_r) begin
            ref_cnt_r <= '0;
            pre_cnt_r <= 3'h0;
            mod_cnt_r <= '0;
        end else begin
            if (rise[0]) begin
                ref_cnt_r <= rdv_tick ? '0 : ref_cnt_r + 4'h1;
            end
            if (rise[1]) begin
                pre_cnt_r <= pclk_tick ? 3'h0 : pre_cnt_r + 3'h1;
            end
            if (pclk_tick) begin
                mod_cnt_r <= fb_tick ? '0 : mod_cnt_r + 12'h001;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rdv_r <= 1'b0;
            pclk_r <= 1'b0;
            fb_r <= 1'b0;
        end else begin
            rdv_r <= rdv_tick;
            pclk_r <= pclk_tick;
            fb_r <= fb_tick;
        end
    end

    // ****************************************************************
    // Phase comparator
    // ****************************************************************
    pll_pkg::pump_t pump_r, pump_nxt;
    wire up_pend = pump_r.up || rdv_tick;
    wire dn_pend = pump_r.down || fb_tick;

    // Leading edge opens its pulse; the lagging edge closes both
    assign pump_nxt.up = on_r && up_pend && !dn_pend;
    assign pump_nxt.down = on_r && dn_pend && !up_pend;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pump_r <= '0;
        end else begin
            pump_r <= pump_nxt;
        end
    end

    // ****************************************************************
    // Lock detector
    // ****************************************************************
    pll_pkg::lock_state_t lk_state_r, lk_state_nxt;
    logic [1:0] fb_cnt_r;
    logic [7:0] good_r;
    wire [1:0] fb_sum = (fb_cnt_r == 2'h2) ? 2'h2 : fb_cnt_r + {1'b0, fb_tick};
    // One feedback edge per reference period means in tolerance
    wire period_good = rdv_tick && (fb_sum == 2'h1);
    wire period_bad = rdv_tick && (fb_sum != 2'h1);
    wire det_run = on_r && auto_r;

    always_comb begin
        lk_state_nxt = lk_state_r;
        case (lk_state_r)
            pll_pkg::LK_IDLE: begin
                lk_state_nxt = pll_pkg::LK_ACQUIRE;
            end
            pll_pkg::LK_ACQUIRE: begin
                if (period_good && good_r >= GOOD_ACQ - 8'h01) begin
                    lk_state_nxt = pll_pkg::LK_TRACK;
                end
            end
            pll_pkg::LK_TRACK: begin
                if (period_bad) begin
                    lk_state_nxt = pll_pkg::LK_ACQUIRE;
                end else if (period_good && good_r >= GOOD_LOCK - 8'h01) begin
                    lk_state_nxt = pll_pkg::LK_LOCKED;
                end
            end
            pll_pkg::LK_LOCKED: begin
                if (period_bad) begin
                    lk_state_nxt = pll_pkg::LK_ACQUIRE;
                end
            end
            default: begin
                lk_state_nxt = pll_pkg::LK_IDLE;
            end
        endcase
        if (!det_run) begin
            lk_state_nxt = pll_pkg::LK_IDLE;
        end
    end

    wire det_acq = (lk_state_nxt == pll_pkg::LK_TRACK) || (lk_state_nxt == pll_pkg::LK_LOCKED);
    assign lock_nxt = (lk_state_nxt == pll_pkg::LK_LOCKED);
    // Auto mode follows the detector; manual mode takes software writes
    assign acq_nxt = auto_r ? det_acq : (wr_bw ? reg_wdata[`BW_ACQ_BIT] : acq_r);

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            lk_state_r <= pll_pkg::LK_IDLE;
            fb_cnt_r <= 2'h0;
            good_r <= 8'h00;
            lock_r <= 1'b0;
        end else begin
            lk_state_r <= lk_state_nxt;
            lock_r <= lock_nxt;
            fb_cnt_r <= (rdv_tick || !det_run) ? 2'h0 : fb_sum;
            if (period_bad || !det_run || lk_state_nxt != lk_state_r) begin
                good_r <= 8'h00;
            end else if (period_good && good_r != 8'hFF) begin
                good_r <= good_r + 8'h01;
            end
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign reg_rdata = rdata_r;
    assign divided_ref_clock = rdv_r;
    assign prescaled_vco_clock = pclk_r;
    assign feedback_clock = fb_r;
    assign pump = pump_r;
    assign track_mode = acq_r;
    assign loop_power_on = on_r;
    assign base_clock_select = bcs_r;
    assign vco_range_linear = lin_r;
    assign vco_range_exp = exp_r;
    assign lock_irq = irq_r;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_manual_ie_zero: assert property (!auto_r |=> !ie_r) else $error("irq enable set in manual mode");
    a_manual_reads_zero: assert property (!auto_r |=> !flag_r && !lock_r)
        else $error("flag or lock set in manual mode");
    a_toggle_sets_flag: assert property ($changed(lock_r) && $past(auto_r) && auto_r |-> flag_r)
        else $error("lock toggle without flag");
    a_irq_follows_flag: assert property (flag_r && ie_r |-> lock_irq)
        else $error("interrupt missing");
    a_prog_frozen: assert property (on_r && $past(on_r) |-> $stable(mul_r) && $stable(pre_r) && $stable(rds_r)
        && $stable(lin_r) && $stable(exp_r)) else $error("program changed while loop on");
    a_auto_acq_ro: assert property ($past(auto_r) |-> acq_r == ((lk_state_r == pll_pkg::LK_TRACK)
        || (lk_state_r == pll_pkg::LK_LOCKED))) else $error("acquire bit not from detector");
    a_manual_acq_wr: assert property (!auto_r && wr_bw |=> acq_r == $past(reg_wdata[`BW_ACQ_BIT]))
        else $error("manual acquire write lost");
    a_lock_needs_auto: assert property (lock_r |-> $past(auto_r) && $past(on_r))
        else $error("lock without auto mode");
    a_pump_exclusive: assert property (!(pump.up && pump.down)) else $error("both pump pulses");
    a_ref_div_wrap: assert property (divided_ref_clock |-> ref_cnt_r == '0)
        else $error("reference divider did not wrap");
    a_fb_div_wrap: assert property (feedback_clock |-> mod_cnt_r == '0 && pre_cnt_r == 3'h0)
        else $error("feedback divider did not wrap");

    c_lock_reached: cover property (auto_r && $rose(lock_r));
    c_lock_lost: cover property (auto_r && $fell(lock_r));
    c_pump_up: cover property ($rose(pump.up) ##[1:20] $fell(pump.up));
    c_bcs_set: cover property ($rose(base_clock_select));

endmodule

// [src/pll_pkg.sv]
// Types shared by the loop divider and lock control block.
// Assumes nothing beyond a SystemVerilog compiler.
package pll_pkg;

    // Correction pulse pair of the phase comparator
    typedef struct packed {
        logic up;
        logic down;
    } pump_t;

    // Lock detector progress
    typedef enum logic [1:0] {
        LK_IDLE,
        LK_ACQUIRE,
        LK_TRACK,
        LK_LOCKED
    } lock_state_t;

endpackage

// [verification/testbench.sv]
// Self-checking bench for the loop divider and lock control block.
// Assumes the design files under src/ are compiled first and that the
// block's assertions live inside its own source.
`timescale 1ns/1ps
`include "pll_consts.svh"

module testbench;
    // ****************************************************************
    // Stimulus and observed signals
    // ****************************************************************
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic ref_clock_in = 1'b0;
    logic vco_clock = 1'b0;
    logic divided_ref_clock;
    logic prescaled_vco_clock;
    logic feedback_clock;
    pll_pkg::pump_t pump;
    logic track_mode;
    logic loop_power_on;
    logic base_clock_select;
    logic [7:0] vco_range_linear;
    logic [1:0] vco_range_exp;
    logic lock_irq;
    int fail_count = 0;
    int n_checks = 0;
    int cyc = 0;
    int c_div = 0;
    int c_pre = 0;
    int c_fb = 0;
    int c_up = 0;
    int c_dn = 0;
    logic [7:0] rd_val;

    pll_divider_lock_control #(.GOOD_ACQ(8'h01), .GOOD_LOCK(8'h02)) dut_u (
        .ref_clk(ref_clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ref_clock_in(ref_clock_in), .vco_clock(vco_clock),
        .divided_ref_clock(divided_ref_clock), .prescaled_vco_clock(prescaled_vco_clock),
        .feedback_clock(feedback_clock), .pump(pump), .track_mode(track_mode),
        .loop_power_on(loop_power_on), .base_clock_select(base_clock_select),
        .vco_range_linear(vco_range_linear), .vco_range_exp(vco_range_exp), .lock_irq(lock_irq)
    );

    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    // ****************************************************************
    // Output pulse counters and hang guard
    // ****************************************************************
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (divided_ref_clock === 1'b1) c_div <= c_div + 1;
        if (prescaled_vco_clock === 1'b1) c_pre <= c_pre + 1;
        if (feedback_clock === 1'b1) c_fb <= c_fb + 1;
        if (pump.up === 1'b1) c_up <= c_up + 1;
        if (pump.down === 1'b1) c_dn <= c_dn + 1;
        if (cyc == 20000) begin
            fail_count = fail_count + 1;
            $display("BAD timeout expected 0 seen 1");
            end_of_test();
        end
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        rd_val = reg_rdata;
    endtask

    task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
        rd(a);
        chk(what, {24'h000000, rd_val}, {24'h000000, exp});
    endtask

    // Makes nr reference rises (half period hr) and nv vco rises (half period hv)
    task automatic pins(input int nr, input int hr, input int nv, input int hv);
        int rr;
        int vr;
        int tot;
        rr = 0;
        vr = 0;
        tot = (nr * 2 * hr > nv * 2 * hv) ? nr * 2 * hr : nv * 2 * hv;
        for (int t = 0; t < tot + 12; t++) begin
            @(posedge ref_clk);
            if (t % (2 * hr) == 0 && rr < nr) begin
                ref_clock_in <= 1'b1;
                rr++;
            end else if (t % (2 * hr) == hr) ref_clock_in <= 1'b0;
            if (t % (2 * hv) == 0 && vr < nv) begin
                vco_clock <= 1'b1;
                vr++;
            end else if (t % (2 * hv) == hv) vco_clock <= 1'b0;
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset_and_lockout();
        rchk("ctrl", `ADDR_CTRL, 8'h20);
        rchk("bw", `ADDR_BW, 8'h00);
        rchk("mul_hi", `ADDR_MUL_HI, 8'h00);
        rchk("mul_lo", `ADDR_MUL_LO, 8'h40);
        rchk("refdiv", `ADDR_REFDIV, 8'h01);
        rchk("unmapped", 8'h50, 8'h00);
        wr(`ADDR_RANGE, 8'h10);
        rchk("range_locked", `ADDR_RANGE, 8'h40);
        chk("lin_out", {24'h0, vco_range_linear}, 32'h40);
        chk("exp_out", {30'h0, vco_range_exp}, 32'h0);
        $display("test reset_and_lockout done");
    endtask

    task automatic t_dividers();
        int d0;
        int p0;
        int f0;
        wr(`ADDR_CTRL, 8'h00);
        wr(`ADDR_REFDIV, 8'h03);
        wr(`ADDR_MUL_LO, 8'h03);
        wr(`ADDR_CTRL, 8'h08);
        wr(`ADDR_CTRL, 8'hA8);
        rchk("ie_forced", `ADDR_CTRL, 8'h28);
        rchk("refdiv_prog", `ADDR_REFDIV, 8'h03);
        d0 = c_div;
        p0 = c_pre;
        f0 = c_fb;
        pins(6, 4, 24, 3);
        chk("div_ref", c_div - d0, 2);
        chk("prescaled", c_pre - p0, 6);
        chk("feedback", c_fb - f0, 2);
        $display("test dividers done");
    endtask

    task automatic t_zero_factors();
        int d0;
        int p0;
        int f0;
        wr(`ADDR_CTRL, 8'h00);
        wr(`ADDR_MUL_HI, 8'hFF);
        rchk("mul_hi_max", `ADDR_MUL_HI, 8'h0F);
        wr(`ADDR_MUL_HI, 8'h00);
        wr(`ADDR_REFDIV, 8'h00);
        wr(`ADDR_MUL_LO, 8'h00);
        wr(`ADDR_CTRL, 8'h20);
        d0 = c_div;
        p0 = c_pre;
        f0 = c_fb;
        pins(4, 4, 5, 3);
        chk("r_zero", c_div - d0, 4);
        chk("p_zero", c_pre - p0, 5);
        chk("n_zero", c_fb - f0, 5);
        $display("test zero_factors done");
    endtask

    task automatic t_auto_lock();
        int u0;
        int n0;
        wr(`ADDR_CTRL, 8'h00);
        wr(`ADDR_REFDIV, 8'h01);
        wr(`ADDR_MUL_LO, 8'h02);
        wr(`ADDR_CTRL, 8'h04);
        wr(`ADDR_BW, 8'h80);
        wr(`ADDR_CTRL, 8'hA4);
        pins(12, 20, 48, 5);
        rchk("bw_locked", `ADDR_BW, 8'hE0);
        chk("track_mode", {31'h0, track_mode}, 1);
        rchk("flag_set", `ADDR_CTRL, 8'hE4);
        chk("irq_on_lock", {31'h0, lock_irq}, 1);
        wr(`ADDR_CTRL, 8'hF4);
        repeat (3) @(posedge ref_clk);
        chk("bcs_after_lock", {31'h0, base_clock_select}, 1);
        chk("irq_cleared", {31'h0, lock_irq}, 0);
        wr(`ADDR_BW, 8'h80);
        rchk("acq_ro", `ADDR_BW, 8'hE0);
        u0 = c_up;
        n0 = c_dn;
        pins(3, 20, 0, 5);
        rchk("bw_lost", `ADDR_BW, 8'h80);
        chk("acq_mode", {31'h0, track_mode}, 0);
        chk("irq_on_loss", {31'h0, lock_irq}, 1);
        chk("pump_up", {31'h0, c_up > u0}, 1);
        chk("pump_up_stands", {31'h0, pump.up}, 1);
        chk("pump_dn", {31'h0, pump.down}, 0);
        $display("test auto_lock done");
    endtask

    task automatic t_manual();
        wr(`ADDR_BW, 8'h00);
        rchk("bw_manual", `ADDR_BW, 8'h00);
        rchk("ctrl_manual", `ADDR_CTRL, 8'h34);
        chk("irq_manual", {31'h0, lock_irq}, 0);
        wr(`ADDR_BW, 8'h20);
        rchk("acq_written", `ADDR_BW, 8'h20);
        chk("track_manual", {31'h0, track_mode}, 1);
        pins(3, 20, 0, 5);
        rchk("no_lock_manual", `ADDR_BW, 8'h20);
        chk("irq_still_off", {31'h0, lock_irq}, 0);
        $display("test manual done");
    endtask

    initial begin
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_reset_and_lockout();
        t_dividers();
        t_zero_factors();
        t_auto_lock();
        t_manual();
        end_of_test();
    end
endmodule
